// >>> rtl/twr_target_rx.sv
// Two-wire target receiver: APB registers, address match, byte receive and clock stretching
`timescale 1ns/10ps
`default_nettype none
`include "twr_regs.svh"
module twr_target_rx
	import twr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic irq,
	output logic wake,
	output logic start_gen
);
	logic scl_s;
	logic sda_s;
	twr_bus_ev_t ev;

	twr_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.scl_s(scl_s),
		.sda_s(sda_s)
	);

	twr_cond u_cond (
		.pclk(pclk),
		.presetn(presetn),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.ev(ev)
	);

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == `TWR_OFF_ADDR) || (a == `TWR_OFF_CTRL) || (a == `TWR_OFF_STAT) ||
			(a == `TWR_OFF_DATA) || (a == `TWR_OFF_AUX);
	endfunction

	// Registers visible to software
	logic [7:0] own_r, own_nxt;
	logic flag_r, flag_nxt;
	logic ack_en_r, ack_en_nxt;
	logic sta_r, sta_nxt;
	logic sto_r, sto_nxt;
	logic wcol_r, wcol_nxt;
	logic en_r, en_nxt;
	logic ie_r, ie_nxt;
	logic [7:0] code_r, code_nxt;
	logic [1:0] presc_r, presc_nxt;
	logic [7:0] data_r, data_nxt;
	logic sleep_r, sleep_nxt;
	logic arb_r, arb_nxt;

	// Bus engine state
	twr_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic ackph_r, ackph_nxt;
	logic ack_r, ack_nxt;
	logic gc_r, gc_nxt;
	logic addressed_r, addressed_nxt;
	logic drop_r, drop_nxt;
	logic busy_r, busy_nxt;

	// Output flops
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic scl_oe_r, scl_oe_nxt;
	logic sda_oe_r, sda_oe_nxt;
	logic irq_r, irq_nxt;
	logic wake_r, wake_nxt;
	logic start_r, start_nxt;
	logic low_r;

	logic wr;
	logic own_hit;
	logic gc_hit;
	logic hit;

	always_comb begin
		own_nxt = own_r;
		flag_nxt = flag_r;
		ack_en_nxt = ack_en_r;
		sta_nxt = sta_r;
		sto_nxt = sto_r;
		wcol_nxt = wcol_r;
		en_nxt = en_r;
		ie_nxt = ie_r;
		code_nxt = code_r;
		presc_nxt = presc_r;
		data_nxt = data_r;
		sleep_nxt = sleep_r;
		arb_nxt = arb_r;
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		ackph_nxt = ackph_r;
		ack_nxt = ack_r;
		gc_nxt = gc_r;
		addressed_nxt = addressed_r;
		drop_nxt = drop_r;
		busy_nxt = busy_r;
		scl_oe_nxt = scl_oe_r;
		sda_oe_nxt = sda_oe_r;
		wake_nxt = 1'b0;
		start_nxt = 1'b0;

		// Zero-wait slave: data is latched in the setup cycle
		pready_nxt = psel && !penable;
		pslverr_nxt = psel && !penable && !addr_ok(paddr);
		prdata_nxt = prdata_r;
		if (psel && !penable) begin
			case (paddr)
				`TWR_OFF_ADDR: prdata_nxt = {24'h000000, own_r};
				`TWR_OFF_CTRL: prdata_nxt = {24'h000000, flag_r, ack_en_r, sta_r, sto_r,
					wcol_r, en_r, 1'b0, ie_r};
				`TWR_OFF_STAT: prdata_nxt = {24'h000000, code_r[7:3], 1'b0, presc_r};
				`TWR_OFF_DATA: prdata_nxt = {24'h000000, data_r};
				`TWR_OFF_AUX: prdata_nxt = {30'h00000000, arb_r, sleep_r};
				default: prdata_nxt = 32'h00000000;
			endcase
		end

		wr = psel && penable && pwrite && pready_r;
		if (wr) begin
			case (paddr)
				`TWR_OFF_ADDR: own_nxt = pwdata[7:0];
				`TWR_OFF_CTRL: begin
					ack_en_nxt = pwdata[`TWR_CTL_ACK];
					sta_nxt = pwdata[`TWR_CTL_STA];
					sto_nxt = pwdata[`TWR_CTL_STO];
					en_nxt = pwdata[`TWR_CTL_EN];
					ie_nxt = pwdata[`TWR_CTL_IE];
					if (pwdata[`TWR_CTL_FLAG]) begin
						flag_nxt = 1'b0;
						code_nxt = `TWR_SC_NONE;
					end
				end
				`TWR_OFF_STAT: presc_nxt = pwdata[1:0];
				`TWR_OFF_DATA: begin
					// Data may only change while the engine is parked
					if (flag_r) begin
						data_nxt = pwdata[7:0];
						wcol_nxt = 1'b0;
					end else begin
						wcol_nxt = 1'b1;
					end
				end
				`TWR_OFF_AUX: begin
					sleep_nxt = pwdata[`TWR_AUX_SLEEP];
					arb_nxt = pwdata[`TWR_AUX_ARB];
				end
				default: ;
			endcase
		end

		// Address zero is the broadcast address, so it never counts as an own match
		own_hit = (shift_r[7:1] == own_r[7:1]) && (own_r[7:1] != 7'h00) && !shift_r[0];
		gc_hit = (shift_r == 8'h00) && own_r[0];
		hit = ack_en_r && (own_hit || gc_hit);

		if (ev.start) begin
			busy_nxt = 1'b1;
		end else if (ev.stop) begin
			busy_nxt = 1'b0;
		end

		// Hardware events come after software writes so a hardware update wins over a write in the same cycle
		if (!en_r || sto_r) begin
			state_nxt = ST_IDLE;
			addressed_nxt = 1'b0;
			scl_oe_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
			ackph_nxt = 1'b0;
			sto_nxt = 1'b0;
		end else if (ev.stop || ev.start) begin
			if (addressed_r) begin
				flag_nxt = 1'b1;
				code_nxt = `TWR_SC_STOP;
			end
			addressed_nxt = 1'b0;
			scl_oe_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
			ackph_nxt = 1'b0;
			cnt_nxt = 4'h0;
			// A repeated start is only listened to when the target is not addressed
			state_nxt = (ev.start && !addressed_r) ? ST_ADDR : ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (!addressed_r && sta_r && !busy_r && !flag_r) begin
						start_nxt = 1'b1;
						sta_nxt = 1'b0;
					end
				end
				ST_ADDR, ST_DATA: begin
					if (ev.scl_rise && !ackph_r && cnt_r != `TWR_BITS) begin
						shift_nxt = {shift_r[6:0], ev.sda};
						cnt_nxt = cnt_r + 4'h1;
					end
					if (ev.scl_fall && ackph_r) begin
						ackph_nxt = 1'b0;
						sda_oe_nxt = 1'b0;
						cnt_nxt = 4'h0;
						flag_nxt = 1'b1;
						scl_oe_nxt = 1'b1;
						state_nxt = ST_HOLD;
						if (state_r == ST_ADDR) begin
							addressed_nxt = 1'b1;
							drop_nxt = 1'b0;
							arb_nxt = 1'b0;
							if (gc_r) begin
								code_nxt = arb_r ? `TWR_SC_ARB_GC : `TWR_SC_GC;
							end else begin
								code_nxt = arb_r ? `TWR_SC_ARB_OWN : `TWR_SC_OWN;
							end
							if (sleep_r) begin
								wake_nxt = 1'b1;
								sleep_nxt = 1'b0;
							end else begin
								data_nxt = shift_r;
							end
						end else begin
							data_nxt = shift_r;
							drop_nxt = !ack_r;
							if (gc_r) begin
								code_nxt = ack_r ? `TWR_SC_GC_ACK : `TWR_SC_GC_NACK;
							end else begin
								code_nxt = ack_r ? `TWR_SC_DATA_ACK : `TWR_SC_DATA_NACK;
							end
						end
					end else if (ev.scl_fall && cnt_r == `TWR_BITS) begin
						if (state_r == ST_ADDR) begin
							if (hit) begin
								ackph_nxt = 1'b1;
								ack_nxt = 1'b1;
								gc_nxt = gc_hit && !own_hit;
								sda_oe_nxt = 1'b1;
							end else begin
								state_nxt = ST_IDLE;
							end
						end else begin
							ackph_nxt = 1'b1;
							ack_nxt = ack_en_r;
							sda_oe_nxt = ack_en_r;
						end
					end
				end
				ST_HOLD: begin
					if (!flag_r) begin
						scl_oe_nxt = 1'b0;
						if (drop_r) begin
							state_nxt = ST_IDLE;
							addressed_nxt = 1'b0;
						end else begin
							state_nxt = ST_DATA;
						end
					end
				end
				default: state_nxt = ST_IDLE;
			endcase
		end

		irq_nxt = flag_r && ie_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_r <= `TWR_RST_ADDR;
			flag_r <= 1'b0;
			ack_en_r <= 1'b0;
			sta_r <= 1'b0;
			sto_r <= 1'b0;
			wcol_r <= 1'b0;
			en_r <= 1'b0;
			ie_r <= 1'b0;
			code_r <= `TWR_RST_CODE;
			presc_r <= 2'h0;
			data_r <= `TWR_RST_DATA;
			sleep_r <= 1'b0;
			arb_r <= 1'b0;
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ackph_r <= 1'b0;
			ack_r <= 1'b0;
			gc_r <= 1'b0;
			addressed_r <= 1'b0;
			drop_r <= 1'b0;
			busy_r <= 1'b0;
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			irq_r <= 1'b0;
			wake_r <= 1'b0;
			start_r <= 1'b0;
			low_r <= 1'b0;
		end else begin
			own_r <= own_nxt;
			flag_r <= flag_nxt;
			ack_en_r <= ack_en_nxt;
			sta_r <= sta_nxt;
			sto_r <= sto_nxt;
			wcol_r <= wcol_nxt;
			en_r <= en_nxt;
			ie_r <= ie_nxt;
			code_r <= code_nxt;
			presc_r <= presc_nxt;
			data_r <= data_nxt;
			sleep_r <= sleep_nxt;
			arb_r <= arb_nxt;
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			ackph_r <= ackph_nxt;
			ack_r <= ack_nxt;
			gc_r <= gc_nxt;
			addressed_r <= addressed_nxt;
			drop_r <= drop_nxt;
			busy_r <= busy_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
			irq_r <= irq_nxt;
			wake_r <= wake_nxt;
			start_r <= start_nxt;
			low_r <= 1'b0;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	// Open-drain: only ever pulls low
	assign scl_o = low_r;
	assign sda_o = low_r;
	assign scl_oe = scl_oe_r;
	assign sda_oe = sda_oe_r;
	assign irq = irq_r;
	assign wake = wake_r;
	assign start_gen = start_r;
endmodule
`default_nettype wire

// >>> rtl/twr_regs.svh
// Register offsets, field positions, reset values and status codes of the two-wire target receiver
`ifndef TWR_REGS_SVH
`define TWR_REGS_SVH

`define TWR_OFF_ADDR 8'h00
`define TWR_OFF_CTRL 8'h04
`define TWR_OFF_STAT 8'h08
`define TWR_OFF_DATA 8'h0c
`define TWR_OFF_AUX 8'h10

`define TWR_CTL_FLAG 7
`define TWR_CTL_ACK 6
`define TWR_CTL_STA 5
`define TWR_CTL_STO 4
`define TWR_CTL_WCOL 3
`define TWR_CTL_EN 2
`define TWR_CTL_IE 0
`define TWR_AUX_SLEEP 0
`define TWR_AUX_ARB 1

`define TWR_RST_ADDR 8'h00
`define TWR_RST_DATA 8'hff
`define TWR_RST_CODE 8'hf8

`define TWR_SC_OWN 8'h60
`define TWR_SC_ARB_OWN 8'h68
`define TWR_SC_GC 8'h70
`define TWR_SC_ARB_GC 8'h78
`define TWR_SC_DATA_ACK 8'h80
`define TWR_SC_DATA_NACK 8'h88
`define TWR_SC_GC_ACK 8'h90
`define TWR_SC_GC_NACK 8'h98
`define TWR_SC_STOP 8'ha0
`define TWR_SC_NONE 8'hf8

`define TWR_BITS 4'h8

`endif

// >>> rtl/twr_pkg.sv
// Types shared by the two-wire target receiver modules
package twr_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_HOLD
	} twr_state_t;

	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} twr_bus_ev_t;

endpackage

// >>> rtl/twr_sync.sv
// Two-flop synchroniser for the bus clock and data pins
`timescale 1ns/10ps
`default_nettype none
module twr_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_s,
	output logic sda_s
);
	logic [1:0] meta_r;
	logic [1:0] sync_r;

	// Idle bus is high, so reset to high to avoid a false start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 2'h3;
			sync_r <= 2'h3;
		end else begin
			meta_r <= {scl_i, sda_i};
			sync_r <= meta_r;
		end
	end

	assign scl_s = sync_r[1];
	assign sda_s = sync_r[0];
endmodule
`default_nettype wire

// >>> rtl/twr_cond.sv
// Edge, start and stop detection on the synchronised bus lines
`timescale 1ns/10ps
`default_nettype none
module twr_cond
	import twr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl_s,
	input wire logic sda_s,
	output twr_bus_ev_t ev
);
	logic scl_d_r;
	logic sda_d_r;
	twr_bus_ev_t ev_r;
	twr_bus_ev_t ev_nxt;

	always_comb begin
		ev_nxt.scl_rise = scl_s && !scl_d_r;
		ev_nxt.scl_fall = !scl_s && scl_d_r;
		// Data moving while the clock is high marks a condition
		ev_nxt.start = scl_s && scl_d_r && sda_d_r && !sda_s;
		ev_nxt.stop = scl_s && scl_d_r && !sda_d_r && sda_s;
		ev_nxt.sda = sda_s;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			ev_r <= '0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			ev_r <= ev_nxt;
		end
	end

	assign ev = ev_r;
endmodule
`default_nettype wire

// >>> test/twr_target_rx_assertions.sv
// Port-level assertions for the two-wire target receiver
`timescale 1ns/10ps
`default_nettype none
`include "twr_regs.svh"
module twr_target_rx_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic irq,
	input wire logic wake,
	input wire logic start_gen
);
	logic [3:0] age_r, age_nxt;
	logic [5:0] ack_r, ack_nxt;
	logic clr;
	assign clr = psel && penable && pready && pwrite && paddr == `TWR_OFF_CTRL && pwdata[`TWR_CTL_FLAG];
	// Age saturates so an old flag clear never looks recent
	always_comb begin
		age_nxt = clr ? 4'h0 : (age_r == 4'hf ? age_r : age_r + 4'h1);
		ack_nxt = sda_oe ? ack_r + 6'h01 : 6'h00;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age_r <= 4'hf;
			ack_r <= 6'h00;
		end else begin
			age_r <= age_nxt;
			ack_r <= ack_nxt;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	AST_RDY_SETUP: assert property (s_setup |=> pready) else $error("no ready after setup");
	AST_RDY_ONE: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	AST_ERR_READ: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("bad error read");
	AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
	AST_OD_LOW: assert property (scl_o == 1'b0 && sda_o == 1'b0) else $error("open drain drives high");
	AST_ACK_LOW: assert property ($rose(sda_oe) |-> !scl_i && !scl_oe) else $error("ack while clock high");
	AST_ACK_LEN: assert property (ack_r <= 6'd30) else $error("ack held too long");
	AST_HOLD_LOW: assert property ($rose(scl_oe) |-> !$past(scl_i)) else $error("hold began while clock high");
	AST_HOLD_REL: assert property ($fell(scl_oe) |-> age_r <= 4'h3) else $error("hold released unasked");
	AST_PULSE: assert property (wake || start_gen |=> !wake && !start_gen) else $error("pulse too long");
endmodule
bind twr_target_rx twr_target_rx_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq),
	.wake(wake), .start_gen(start_gen));
`default_nettype wire

// >>> test/twr_master.sv
// Bus master transmitter model on the open-drain lines
`timescale 1ns/10ps
`default_nettype none
module twr_master (
	output logic scl_m,
	output logic sda_m,
	input wire logic scl_l,
	input wire logic sda_l
);
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	// Waits out clock stretching; bounded so a stuck hold cannot hang
	task automatic rise(output logic v);
		scl_m = 1'b1;
		for (int i = 0; i < 5000 && !scl_l; i++) #10;
		#31.25;
		v = sda_l;
		#31.25;
	endtask
	task automatic go_start();
		sda_m = 1'b0;
		#62.5;
		scl_m = 1'b0;
		#31.25;
	endtask
	task automatic send(input logic [7:0] b, output logic nk);
		logic v;
		for (int i = 8; i >= 0; i--) begin
			sda_m = (i == 0) ? 1'b1 : b[i-1];
			#31.25;
			rise(v);
			scl_m = 1'b0;
			#31.25;
		end
		nk = v;
	endtask
	task automatic go_stop();
		logic v;
		sda_m = 1'b0;
		#31.25;
		rise(v);
		sda_m = 1'b1;
		#62.5;
	endtask
endmodule
`default_nettype wire

// >>> test/tb_two_wire_target_receiver.sv
// Self-checking bench for the two-wire target receiver
`timescale 1ns/10ps
`default_nettype none
`include "twr_regs.svh"
module tb_two_wire_target_receiver;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, wake, start_gen, scl_m, sda_m, e, nk;
	logic wake_seen = 1'b0;
	logic sg_seen = 1'b0;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	wire scl_l = scl_m & ~scl_oe;
	wire sda_l = sda_m & ~sda_oe;
	always #5 pclk = ~pclk;
	twr_target_rx uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_l),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_l), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq), .wake(wake),
		.start_gen(start_gen));
	twr_master bm (.scl_m(scl_m), .sda_m(sda_m), .scl_l(scl_l), .sda_l(sda_l));
	task automatic results();
		if (error_cnt == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (wake) wake_seen <= 1'b1;
		if (start_gen) sg_seen <= 1'b1;
		if (cyc == 60000) begin
			error_cnt++;
			results();
		end
	end
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			$display("CHECK FAILED %s expected %h seen %h", s, x, g);
			error_cnt++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Ends when pready is seen high; only the global cycle limit ends a stuck wait
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), q, {24'h0, x});
	endtask
	// Optional start, one byte, then the acknowledge and the reported code
	task automatic xfer(input logic s, input logic [7:0] b, input logic x, input logic [7:0] c);
		if (s) bm.go_start();
		bm.send(b, nk);
		chk("nack", nk, x);
		rdc(`TWR_OFF_STAT, c);
	endtask
	task automatic t_reset();
		rdc(`TWR_OFF_ADDR, `TWR_RST_ADDR);
		rdc(`TWR_OFF_CTRL, 8'h00);
		rdc(`TWR_OFF_STAT, `TWR_RST_CODE);
		rdc(`TWR_OFF_DATA, `TWR_RST_DATA);
		rdc(`TWR_OFF_AUX, 8'h00);
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", e, 1);
		wr(`TWR_OFF_STAT, 8'h03);
		rdc(`TWR_OFF_STAT, 8'hfb);
		wr(`TWR_OFF_STAT, 8'h00);
	endtask
	task automatic t_own();
		wr(`TWR_OFF_ADDR, 8'h55);
		wr(`TWR_OFF_CTRL, 8'h45);
		xfer(1, 8'h54, 0, `TWR_SC_OWN);
		chk("irq", irq, 1);
		chk("hold", scl_oe, 1);
		wr(`TWR_OFF_CTRL, 8'hc5);
		xfer(0, 8'ha5, 0, `TWR_SC_DATA_ACK);
		rdc(`TWR_OFF_DATA, 8'ha5);
		wr(`TWR_OFF_CTRL, 8'h84);
		xfer(0, 8'h3c, 1, `TWR_SC_DATA_NACK);
		chk("irq", irq, 0);
		wr(`TWR_OFF_CTRL, 8'hc4);
		bm.go_stop();
		rdc(`TWR_OFF_STAT, `TWR_SC_NONE);
		xfer(1, 8'h54, 0, `TWR_SC_OWN);
		wr(`TWR_OFF_CTRL, 8'hc4);
		bm.go_stop();
		rdc(`TWR_OFF_STAT, `TWR_SC_STOP);
		wr(`TWR_OFF_CTRL, 8'hc4);
		wr(`TWR_OFF_CTRL, 8'h64);
		repeat (50) @(posedge pclk);
		chk("start", sg_seen, 1);
	endtask
	task automatic t_gc();
		xfer(1, 8'h00, 0, `TWR_SC_GC);
		wr(`TWR_OFF_CTRL, 8'hc4);
		xfer(0, 8'h11, 0, `TWR_SC_GC_ACK);
		rdc(`TWR_OFF_DATA, 8'h11);
		wr(`TWR_OFF_CTRL, 8'h84);
		xfer(0, 8'h22, 1, `TWR_SC_GC_NACK);
		wr(`TWR_OFF_CTRL, 8'hc4);
		bm.go_stop();
	endtask
	task automatic t_refuse();
		wr(`TWR_OFF_ADDR, 8'h00);
		xfer(1, 8'h00, 1, `TWR_SC_NONE);
		bm.go_stop();
		wr(`TWR_OFF_ADDR, 8'h54);
		xfer(1, 8'h00, 1, `TWR_SC_NONE);
		bm.go_stop();
		xfer(1, 8'h56, 1, `TWR_SC_NONE);
		bm.go_stop();
		wr(`TWR_OFF_CTRL, 8'h04);
		xfer(1, 8'h54, 1, `TWR_SC_NONE);
		bm.go_stop();
		wr(`TWR_OFF_CTRL, 8'h44);
		xfer(1, 8'h54, 0, `TWR_SC_OWN);
		// Stop request while addressed releases the lines and leaves nothing to report
		wr(`TWR_OFF_CTRL, 8'hd4);
		bm.go_stop();
		rdc(`TWR_OFF_STAT, `TWR_SC_NONE);
		rdc(`TWR_OFF_CTRL, 8'h44);
	endtask
	task automatic t_arb();
		logic [7:0] ad [2];
		logic [7:0] cd [2];
		ad = '{8'h54, 8'h00};
		cd = '{`TWR_SC_ARB_OWN, `TWR_SC_ARB_GC};
		wr(`TWR_OFF_ADDR, 8'h55);
		for (int i = 0; i < 2; i++) begin
			wr(`TWR_OFF_AUX, 8'h02);
			xfer(1, ad[i], 0, cd[i]);
			wr(`TWR_OFF_CTRL, 8'hc4);
			bm.go_stop();
			wr(`TWR_OFF_CTRL, 8'hc4);
		end
	endtask
	task automatic t_sleep();
		chk("wake", wake_seen, 0);
		wr(`TWR_OFF_AUX, 8'h01);
		xfer(1, 8'h54, 0, `TWR_SC_OWN);
		chk("wake", wake_seen, 1);
		rdc(`TWR_OFF_DATA, 8'h00);
		repeat (100) @(posedge pclk);
		chk("hold", scl_oe, 1);
		wr(`TWR_OFF_CTRL, 8'hc4);
		xfer(0, 8'h77, 0, `TWR_SC_DATA_ACK);
		rdc(`TWR_OFF_DATA, 8'h77);
		wr(`TWR_OFF_CTRL, 8'hc4);
		bm.go_stop();
		wr(`TWR_OFF_CTRL, 8'hc4);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_reset();
		t_own();
		t_gc();
		t_refuse();
		t_arb();
		t_sleep();
		results();
	end
endmodule
`default_nettype wire
